// [core/addr_map_decoder.sv]
// file: address map decoder with program counter and stack pointer sequencing
// assumes the core drives one request at a time, synchronous to clk_sys; code
// bytes arrive on fetch_data in the cycle after fetch_addr is presented
// the reset vector takes three cycles: low byte address, high byte address, load
// the external window stops below the reserved gap under the RAM
`timescale 1ns/10ps
`default_nettype none

module addr_map_decoder
	import addr_map_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        size_wr,
	input  wire logic [7:0]  size_wdata,
	input  wire logic        ext_enable,
	input  wire logic [15:0] data_addr,
	input  wire pc_req_s     pc_req,
	input  wire logic        sp_load,
	input  wire logic [15:0] sp_wdata,
	input  wire logic        stack_push,
	input  wire logic        stack_pop,
	input  wire logic [7:0]  fetch_data,
	output logic [7:0]       size_sel,
	output logic [15:0]      pc,
	output logic             pc_ready,
	output logic [15:0]      fetch_addr,
	output decode_s          fetch_dec,
	output decode_s          data_dec,
	output logic [15:0]      sp,
	output logic [15:0]      stack_addr,
	output logic             stack_in_ram
);

	logic [7:0]  size_sel_ff;
	logic [15:0] pc_ff;
	logic [15:0] nxt_pc;
	logic [15:0] sp_ff;
	logic [7:0]  vec_lo_ff;
	pc_state_e   pcs_ff;
	decode_s     fetch_dec_ff;
	decode_s     data_dec_ff;
	logic [15:0] rom_top;
	logic [15:0] ram_base;

	// rom top and ram base from the size select value
	always_comb begin
		case (size_sel_ff)
			MSS_ROM8K:  rom_top = ROM_TOP_8K;
			MSS_ROM16K: rom_top = ROM_TOP_16K;
			MSS_ROM24K: rom_top = ROM_TOP_24K;
			MSS_ROM32K: rom_top = ROM_TOP_32K;
			default:    rom_top = ROM_TOP_32K;
		endcase
		case (size_sel_ff)
			MSS_ROM8K:  ram_base = RAM_BASE_512;
			MSS_ROM16K: ram_base = RAM_BASE_512;
			MSS_ROM24K: ram_base = RAM_BASE_1K;
			MSS_ROM32K: ram_base = RAM_BASE_1K;
			default:    ram_base = RAM_BASE_1K;
		endcase
	end

	// high speed RAM window for the selected size, shared by decode and the stack check
	function automatic logic in_ram(input logic [15:0] a, input logic [15:0] rbase);
		return (a >= rbase) && (a <= RAM_TOP);
	endfunction : in_ram

	// even slots only: reset, watchdog, external and peripheral run, break
	function automatic logic vec_slot(input logic [15:0] a);
		logic hit;
		hit = (a == VEC_RESET_LO) || (a == VEC_WATCHDOG);
		hit = hit || ((a >= VEC_EXT_FIRST) && (a <= VEC_PERIPH_LAST));
		hit = hit || (a == VEC_BREAK);
		return hit && (a[0] == 1'b0);
	endfunction : vec_slot

	function automatic decode_s decode(input logic [15:0] a, input logic [15:0] top,
			input logic [15:0] rbase, input logic ext);
		decode_s d;
		d = '0;
		d.region = REG_UNMAPPED;
		if (a <= top) begin
			d.region = REG_ROM;
		end else if (a >= SFR_BASE) begin
			d.region = REG_SFR;
		end else if (a >= BANK_BASE) begin
			d.region = REG_BANK;
		end else if (in_ram(a, rbase)) begin
			d.region = REG_RAM;
		end else if (ext && a <= EXT_TOP) begin
			// the reserved gap below the RAM stays unmapped
			d.region = REG_EXT;
		end
		d.is_vector = (a <= VEC_TOP);
		d.is_tcall  = (a >= TCALL_BASE && a <= TCALL_TOP);
		d.is_scall  = (a >= SCALL_BASE && a <= SCALL_TOP);
		d.is_vec_slot = vec_slot(a);
		d.bank     = 2'h3 - a[4:3];
		d.bank_reg = a[2:0];
		return d;
	endfunction : decode

	// fetch address walks the two vector bytes, then follows the counter
	assign fetch_addr = (pcs_ff == PCS_VEC_LO) ? VEC_RESET_LO :
		(pcs_ff == PCS_VEC_HI) ? VEC_RESET_HI : pc_ff;
	assign pc_ready   = (pcs_ff == PCS_RUN);

	// size select register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			size_sel_ff <= MSS_RESET;
		end else if (size_wr) begin
			size_sel_ff <= size_wdata;
		end
	end

	// decoder outputs are registered, one cycle after the address
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fetch_dec_ff <= '0;
			data_dec_ff  <= '0;
		end else begin
			fetch_dec_ff <= decode(fetch_addr, rom_top, ram_base, ext_enable);
			data_dec_ff  <= decode(data_addr, rom_top, ram_base, ext_enable);
		end
	end

	always_comb begin
		nxt_pc = pc_ff;
		if (pc_req.branch) begin
			nxt_pc = pc_req.target;
		end else if (pc_req.advance) begin
			nxt_pc = pc_ff + {14'h0000, pc_req.length};
		end
	end

	// reset vector load, then normal sequencing
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pcs_ff    <= PCS_VEC_LO;
			pc_ff     <= '0;
			vec_lo_ff <= '0;
		end else begin
			case (pcs_ff)
				PCS_VEC_LO: begin
					pcs_ff <= PCS_VEC_HI;
				end
				PCS_VEC_HI: begin
					// byte fetched from the even vector address
					vec_lo_ff <= fetch_data;
					pcs_ff    <= PCS_VEC_LD;
				end
				PCS_VEC_LD: begin
					pc_ff  <= {fetch_data, vec_lo_ff};
					pcs_ff <= PCS_RUN;
				end
				PCS_RUN: begin
					// requests are only taken here; the vector load ignores them
					pc_ff <= nxt_pc;
				end
				default: begin
					pcs_ff <= PCS_VEC_LO;
				end
			endcase
		end
	end

	// stack pointer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sp_ff <= '0;
		end else if (sp_load) begin
			sp_ff <= sp_wdata;
		end else if (stack_push) begin
			sp_ff <= sp_ff - 16'h0001;
		end else if (stack_pop) begin
			sp_ff <= sp_ff + 16'h0001;
		end
	end

	// push writes at sp-1, pop reads at sp
	assign stack_addr   = stack_push ? (sp_ff - 16'h0001) : sp_ff;
	assign stack_in_ram = in_ram(stack_addr, ram_base);

	assign size_sel  = size_sel_ff;
	assign pc        = pc_ff;
	assign sp        = sp_ff;
	assign fetch_dec = fetch_dec_ff;
	assign data_dec  = data_dec_ff;

endmodule : addr_map_decoder

`default_nettype wire

// [core/addr_map_pkg.sv]
// package: address map constants, region codes and carrier structs for the decoder
// assumes a 16-bit byte address space and an 8-bit code fetch path
package addr_map_pkg;

	// memory size select values
	localparam logic [7:0]  MSS_RESET       = 8'hCF;
	localparam logic [7:0]  MSS_ROM8K       = 8'h42;
	localparam logic [7:0]  MSS_ROM16K      = 8'h44;
	localparam logic [7:0]  MSS_ROM24K      = 8'hC6;
	localparam logic [7:0]  MSS_ROM32K      = 8'hC8;

	// program memory
	localparam logic [15:0] ROM_BASE        = 16'h0000;
	localparam logic [15:0] ROM_TOP_8K      = 16'h1FFF;
	localparam logic [15:0] ROM_TOP_16K     = 16'h3FFF;
	localparam logic [15:0] ROM_TOP_24K     = 16'h5FFF;
	localparam logic [15:0] ROM_TOP_32K     = 16'h7FFF;
	localparam logic [15:0] VEC_BASE        = 16'h0000;
	localparam logic [15:0] VEC_TOP         = 16'h003F;
	localparam logic [15:0] VEC_RESET_LO    = 16'h0000;
	localparam logic [15:0] VEC_RESET_HI    = 16'h0001;
	localparam logic [15:0] VEC_WATCHDOG    = 16'h0004;
	localparam logic [15:0] VEC_EXT_FIRST   = 16'h0006;
	localparam logic [15:0] VEC_EXT_LAST    = 16'h000C;
	localparam logic [15:0] VEC_PERIPH_LAST = 16'h0028;
	localparam logic [15:0] VEC_BREAK       = 16'h003E;
	localparam logic [15:0] TCALL_BASE      = 16'h0040;
	localparam logic [15:0] TCALL_TOP       = 16'h007F;
	localparam logic [15:0] SCALL_BASE      = 16'h0800;
	localparam logic [15:0] SCALL_TOP       = 16'h0FFF;

	// data memory
	localparam logic [15:0] RAM_BASE_512    = 16'hFD00;
	localparam logic [15:0] RAM_BASE_1K     = 16'hFB00;
	localparam logic [15:0] RAM_TOP         = 16'hFEFF;
	localparam logic [15:0] EXT_TOP         = 16'hF7FF;
	localparam logic [15:0] BANK_BASE       = 16'hFEE0;
	localparam logic [15:0] BANK_TOP        = 16'hFEFF;
	localparam logic [15:0] SFR_BASE        = 16'hFF00;
	localparam logic [15:0] SFR_TOP         = 16'hFFFF;
	localparam logic [1:0]  PC_LEN_MAX      = 2'h3;

	typedef enum logic [2:0] {
		REG_UNMAPPED = 3'b000,
		REG_ROM      = 3'b001,
		REG_RAM      = 3'b010,
		REG_BANK     = 3'b011,
		REG_SFR      = 3'b100,
		REG_EXT      = 3'b101
	} region_e;

	typedef enum logic [1:0] {
		PCS_VEC_LO = 2'b00,
		PCS_VEC_HI = 2'b01,
		PCS_RUN    = 2'b10,
		PCS_VEC_LD = 2'b11
	} pc_state_e;

	// decoded view of one address
	typedef struct packed {
		region_e     region;
		logic        is_vector;
		logic        is_tcall;
		logic        is_scall;
		logic        is_vec_slot;
		logic [1:0]  bank;
		logic [2:0]  bank_reg;
	} decode_s;

	// instruction flow request from the core
	typedef struct packed {
		logic        advance;
		logic [1:0]  length;
		logic        branch;
		logic [15:0] target;
	} pc_req_s;

endpackage : addr_map_pkg

// [tb/addr_map_asserts.sv]
// checker: port timing of the address map decoder
// assumes one clock clk_sys and active-low reset rst_b
`timescale 1ns/10ps
`default_nettype none
module addr_map_asserts
	import addr_map_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        size_wr,
	input wire logic [7:0]  size_wdata,
	input wire logic [15:0] data_addr,
	input wire pc_req_s     pc_req,
	input wire logic        sp_load,
	input wire logic        stack_push,
	input wire logic        stack_pop,
	input wire logic [7:0]  fetch_data,
	input wire logic [7:0]  size_sel,
	input wire logic [15:0] pc,
	input wire logic        pc_ready,
	input wire logic [15:0] fetch_addr,
	input wire decode_s     data_dec,
	input wire logic [15:0] sp,
	input wire logic [15:0] stack_addr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_size; size_wr |=> size_sel == $past(size_wdata); endproperty
	a_size: assert property (p_size) else $error("size select not written");
	property p_push; stack_push && !sp_load |=> sp == $past(sp) - 16'h1; endproperty
	a_push: assert property (p_push) else $error("push did not predecrement");
	property p_pop; stack_pop && !stack_push && !sp_load |=> sp == $past(sp) + 16'h1; endproperty
	a_pop: assert property (p_pop) else $error("pop did not postincrement");
	property p_paddr; stack_push && !sp_load |-> stack_addr == sp - 16'h1; endproperty
	a_paddr: assert property (p_paddr) else $error("push address wrong");
	property p_br; pc_ready && pc_req.branch |=> pc == $past(pc_req.target); endproperty
	a_br: assert property (p_br) else $error("branch target not loaded");
	property p_adv;
		pc_ready && pc_req.advance && !pc_req.branch |=> pc == $past(pc) + $past(pc_req.length);
	endproperty
	a_adv: assert property (p_adv) else $error("counter step wrong");
	property p_fetch; pc_ready |-> fetch_addr == pc; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address not counter");
	property p_vec; $rose(pc_ready) |-> pc[15:8] == $past(fetch_data); endproperty
	a_vec: assert property (p_vec) else $error("reset vector high byte not loaded");
	property p_sfr; data_addr[15:8] == 8'hFF |=> data_dec.region == REG_SFR; endproperty
	a_sfr: assert property (p_sfr) else $error("register page not decoded");
endmodule : addr_map_asserts
`default_nettype wire

// [tb/code_mem_model.sv]
// partner: code memory answering each fetch address one cycle later
// assumes the reset vector target is set by parameter
`timescale 1ns/10ps
`default_nettype none
module code_mem_model
	import addr_map_pkg::*;
#(parameter logic [15:0] RESET_TARGET = 16'h1234)
(
	input  wire logic        clk_sys,
	input  wire logic [15:0] fetch_addr,
	output logic [7:0]       fetch_data
);
	always_ff @(posedge clk_sys) begin
		if (fetch_addr == VEC_RESET_LO)
			fetch_data <= RESET_TARGET[7:0];
		else if (fetch_addr == VEC_RESET_HI)
			fetch_data <= RESET_TARGET[15:8];
		else
			fetch_data <= ~fetch_addr[7:0];
	end
endmodule : code_mem_model
`default_nettype wire

// [tb/cpu_address_map_decoder_tb_top.sv]
// testbench: decode table, reset vector, counter and stack sequences
// assumes inputs change on the falling edge of clk_sys
`timescale 1ns/10ps
`default_nettype none
module cpu_address_map_decoder_tb_top;
	import addr_map_pkg::*;
	typedef struct packed {logic [7:0] sz; logic ex; logic [15:0] a; region_e r;} row_s;
	logic        clk_sys = 1'b0, rst_b = 1'b0, size_wr = 1'b0, ext_enable = 1'b0;
	logic        sp_load = 1'b0, stack_push = 1'b0, stack_pop = 1'b0, pc_ready, stack_in_ram;
	logic [7:0]  size_wdata = 8'h00, fetch_data, size_sel;
	logic [15:0] data_addr = 16'h0000, sp_wdata = 16'h0000, pc, fetch_addr, sp, stack_addr;
	pc_req_s     pc_req = '0;
	decode_s     fetch_dec, data_dec;
	int          err_total = 0, num_checks = 0, cyc = 0;
	row_s rows [13] = '{'{8'hC8,1'b1,16'h8000,REG_EXT}, '{8'hC8,1'b0,16'h8000,REG_UNMAPPED},
		'{8'hC8,1'b0,16'h7FFF,REG_ROM}, '{8'hC8,1'b0,16'hFB00,REG_RAM},
		'{8'hC8,1'b0,16'hFEE0,REG_BANK}, '{8'h42,1'b0,16'h1FFF,REG_ROM},
		'{8'h42,1'b0,16'h2000,REG_UNMAPPED}, '{8'h42,1'b1,16'hF7FF,REG_EXT},
		'{8'h42,1'b1,16'hFCFF,REG_UNMAPPED}, '{8'h44,1'b0,16'h3FFF,REG_ROM},
		'{8'hC6,1'b1,16'h6000,REG_EXT}, '{8'hC8,1'b0,16'hFF00,REG_SFR},
		'{8'hC6,1'b0,16'hFB00,REG_RAM}};
	addr_map_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .size_wr(size_wr),
		.size_wdata(size_wdata), .ext_enable(ext_enable), .data_addr(data_addr),
		.pc_req(pc_req), .sp_load(sp_load), .sp_wdata(sp_wdata), .stack_push(stack_push),
		.stack_pop(stack_pop), .fetch_data(fetch_data), .size_sel(size_sel), .pc(pc),
		.pc_ready(pc_ready), .fetch_addr(fetch_addr), .fetch_dec(fetch_dec),
		.data_dec(data_dec), .sp(sp), .stack_addr(stack_addr), .stack_in_ram(stack_in_ram));
	code_mem_model mem (.clk_sys(clk_sys), .fetch_addr(fetch_addr), .fetch_data(fetch_data));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask : chk
	task automatic dec(input logic [15:0] a);
		data_addr = a;
		@(negedge clk_sys);
	endtask : dec
	// reset release walk: two vector byte fetches, then the counter runs
	task automatic vec_load;
		chk("pc_ready", 16'h0, pc_ready);
		chk("fetch_addr", 16'h0000, fetch_addr);
		rst_b = 1'b1;
		@(negedge clk_sys);
		chk("fetch_addr", 16'h0001, fetch_addr);
		@(negedge clk_sys);
		chk("pc_ready", 16'h0, pc_ready);
		@(negedge clk_sys);
		chk("pc_ready", 16'h1, pc_ready);
		chk("pc", 16'h1234, pc);
	endtask : vec_load
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		chk("size_sel", MSS_RESET, size_sel);
		chk("sp", 16'h0000, sp);
		chk("in_ram", 16'h0, stack_in_ram);
		vec_load();
		for (int i = 0; i < 13; i++) begin
			size_wr = 1'b1;
			size_wdata = rows[i].sz;
			ext_enable = rows[i].ex;
			data_addr = rows[i].a;
			@(negedge clk_sys);
			size_wr = 1'b0;
			@(negedge clk_sys);
			chk("region", rows[i].r, data_dec.region);
		end
		dec(16'h003E);
		chk("vector", 16'h3, {data_dec.is_vector, data_dec.is_vec_slot});
		dec(16'h0040);
		chk("tcall", 16'h1, data_dec.is_tcall);
		dec(16'h0800);
		chk("scall", 16'h1, data_dec.is_scall);
		dec(16'hFEE0);
		chk("bank", 16'h3, data_dec.bank);
		pc_req = '{1'b1, 2'h3, 1'b0, 16'h0000};
		@(negedge clk_sys);
		chk("pc", 16'h1237, pc);
		pc_req = '{1'b1, 2'h1, 1'b1, 16'h0800};
		@(negedge clk_sys);
		chk("pc", 16'h0800, pc);
		pc_req = '{1'b1, 2'h2, 1'b0, 16'h0000};
		@(negedge clk_sys);
		chk("pc", 16'h0802, pc);
		chk("fetch_scall", 16'h1, fetch_dec.is_scall);
		chk("fetch_region", REG_ROM, fetch_dec.region);
		pc_req = '0;
		sp_load = 1'b1;
		sp_wdata = 16'hFB01;
		@(negedge clk_sys);
		sp_load = 1'b0;
		stack_push = 1'b1;
		#1;
		chk("stack_addr", 16'hFB00, stack_addr);
		chk("in_ram", 16'h1, stack_in_ram);
		@(negedge clk_sys);
		stack_push = 1'b0;
		stack_pop = 1'b1;
		chk("sp", 16'hFB00, sp);
		@(negedge clk_sys);
		stack_pop = 1'b0;
		chk("sp", 16'hFB01, sp);
		#1;
		chk("in_ram", 16'h1, stack_in_ram);
		@(negedge clk_sys);
		rst_b = 1'b0;
		#1;
		chk("size_sel", MSS_RESET, size_sel);
		chk("pc", 16'h0000, pc);
		chk("sp", 16'h0000, sp);
		@(negedge clk_sys);
		vec_load();
		wrap_up();
	end
endmodule : cpu_address_map_decoder_tb_top
bind addr_map_decoder addr_map_asserts chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
	.size_wr(size_wr), .size_wdata(size_wdata), .data_addr(data_addr), .pc_req(pc_req),
	.sp_load(sp_load), .stack_push(stack_push), .stack_pop(stack_pop), .size_sel(size_sel),
	.pc(pc), .pc_ready(pc_ready), .fetch_addr(fetch_addr), .data_dec(data_dec), .sp(sp),
	.stack_addr(stack_addr), .fetch_data(fetch_data));
`default_nettype wire
